// >>> design/maint_cmd_pkg.sv
// Constants and types shared by the maintenance command interpreter
package maint_cmd_pkg;
  // ****************************************
  // Command and response codes
  // ****************************************
  localparam logic [15:0] CMD_IDLE    = 16'h0000;
  localparam logic [15:0] CMD_RESTORE = 16'h1000;
  localparam logic [15:0] CMD_BACKUP  = 16'h1001;
  localparam logic [15:0] CMD_RESET   = 16'h8000;
  localparam logic [15:0] RESET_SOFT  = 16'h0000;
  localparam logic [15:0] RESET_VOLT  = 16'h0001;
  localparam logic [7:0]  ERR_NONE      = 8'h00;
  localparam logic [7:0]  ERR_NO_BACKUP = 8'h01;
  localparam logic [7:0]  ERR_NOT_UHF   = 8'h02;
  localparam logic [7:0]  ERR_BAD_CMD   = 8'h03;
  localparam logic [7:0]  ERR_BAD_TYPE  = 8'h04;

  // ****************************************
  // Register map (Wishbone byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_COMMAND  = 8'h00;
  localparam logic [7:0] ADDR_START    = 8'h04;
  localparam logic [7:0] ADDR_CHANNEL  = 8'h08;
  localparam logic [7:0] ADDR_RESPONSE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_BACKUP   = 8'h1C;

  // Channel register: bit 0 selects UHF, bits 3:1 the head address
  localparam int CHAN_UHF_BIT = 0;
  localparam int CHAN_HEAD_LSB = 1;
  // Interrupt bits
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_ERROR_BIT = 1;
  localparam int IRQ_RESET_BIT = 2;
  localparam int IRQ_WIDTH     = 3;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int SETTINGS_WORDS = 8;
  localparam int STEP_CYCLES    = 1;

  typedef enum logic [2:0] {
    IDLE    = 3'b000,
    DECODE  = 3'b001,
    XFER    = 3'b011,
    DONE    = 3'b010,
    CLEAR   = 3'b110
  } state_t;
endpackage

// >>> design/backup_store.sv
// Backup memory holding the saved reader settings, registered read port
`timescale 1ns/1ns
module backup_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clock,
  input  wire logic             write_en,
  input  wire logic [AW-1:0]    write_addr,
  input  wire logic [WIDTH-1:0] write_data,
  input  wire logic [AW-1:0]    read_addr,
  output logic      [WIDTH-1:0] read_data
);
  // No reset on purpose: contents stand for non-volatile storage
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (write_en)
    begin
      mem[write_addr] <= write_data;
    end
  end

  always_ff @(posedge clock)
  begin
    read_data <= mem[read_addr];
  end
endmodule

// >>> design/maint_cmd.sv
// Restore, backup and reset command interpreter with Wishbone registers
//
// Behaviour
// - Restore and backup run only on a channel configured for UHF
// - Command 0x1000 loads the stored settings into the attached UHF reader
// - Command 0x1001 reads reader settings into the backup memory
// - Backup memory and its valid flag survive voltage or software reset
// - Command 0x8000 resets the addressed reader and the interface logic
// - Reset clears only the output image (command, start address); channel and backup memory are kept
// - Start address 0 selects software reset, 1 voltage reset
// - On completion the response code equals the executed command code
`timescale 1ns/1ns
module maint_cmd
  import maint_cmd_pkg::*;
#(
  parameter int WORDS = maint_cmd_pkg::SETTINGS_WORDS
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  output logic             irq,
  output logic             reader_we,
  output logic [2:0]       reader_head,
  output logic [2:0]       reader_addr,
  output logic [31:0]      reader_wdata,
  input  wire logic [31:0] reader_rdata,
  output logic             reader_reset,
  output logic             reader_power_cycle
);
  localparam int AW = $clog2(WORDS);

  state_t           state;
  logic [15:0]      command;
  logic [15:0]      start_addr;
  logic [3:0]       channel;
  logic [15:0]      response;
  logic [7:0]       error;
  logic             busy;
  logic             backup_valid;
  logic [IRQ_WIDTH-1:0] irq_stat;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [AW-1:0]    index;
  logic             phase;
  logic [15:0]      exec_cmd;
  logic             store_we;
  logic [31:0]      store_rdata;
  logic             req;
  logic             wr;
  logic             done_ev;
  logic             err_ev;
  logic             rst_ev;
  logic             clear_images;
  logic             is_uhf;

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Answer one cycle after the request; ack drops in the next cycle
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i;
  assign is_uhf = channel[CHAN_UHF_BIT];

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge clock)
  begin
    wb_ack_o <= !reset && req;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wb_dat_o <= RESET_WORD;
    end
    else if (req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        ADDR_COMMAND:  wb_dat_o <= {16'h0000, command};
        ADDR_START:    wb_dat_o <= {16'h0000, start_addr};
        ADDR_CHANNEL:  wb_dat_o <= {28'h0000000, channel};
        ADDR_RESPONSE: wb_dat_o <= {8'h00, error, response};
        ADDR_STATUS:   wb_dat_o <= {30'h0, backup_valid, busy};
        ADDR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat};
        ADDR_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask};
        default:       wb_dat_o <= RESET_WORD;
      endcase
    end
  end

  // Output image: command and start address, cleared by the reset command
  always_ff @(posedge clock)
  begin
    if (reset || clear_images)
    begin
      command    <= CMD_IDLE;
      start_addr <= RESET_SOFT;
    end
    else if (wr && wb_adr_i == ADDR_COMMAND)
    begin
      command <= merge16(command, wb_dat_i, wb_sel_i);
    end
    else if (wr && wb_adr_i == ADDR_START)
    begin
      start_addr <= merge16(start_addr, wb_dat_i, wb_sel_i);
    end
  end

  // Channel configuration is set-up, not process data: kept across command reset
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      channel <= 4'h0;
    end
    else if (wr && wb_adr_i == ADDR_CHANNEL && wb_sel_i[0])
    begin
      channel <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irq_mask <= '0;
    end
    else if (wr && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0])
    begin
      irq_mask <= wb_dat_i[IRQ_WIDTH-1:0];
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irq_stat <= '0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~((wr && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0])
                                ? wb_dat_i[IRQ_WIDTH-1:0] : '0))
                  | {rst_ev, err_ev, done_ev};
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state        <= IDLE;
      exec_cmd     <= CMD_IDLE;
      index        <= '0;
      phase        <= 1'b0;
      error        <= ERR_NONE;
      response     <= CMD_IDLE;
      clear_images <= 1'b0;
      done_ev      <= 1'b0;
      err_ev       <= 1'b0;
      rst_ev       <= 1'b0;
      reader_reset <= 1'b0;
      reader_power_cycle <= 1'b0;
    end
    else
    begin
      clear_images <= 1'b0;
      done_ev      <= 1'b0;
      err_ev       <= 1'b0;
      rst_ev       <= 1'b0;
      reader_reset <= 1'b0;
      reader_power_cycle <= 1'b0;
      unique case (state)
        IDLE:
        begin
          // A new command is one that differs from the last one executed
          if (command != exec_cmd)
          begin
            exec_cmd <= command;
            state    <= (command == CMD_IDLE) ? IDLE : DECODE;
            if (command == CMD_IDLE)
            begin
              response <= CMD_IDLE;
              error    <= ERR_NONE;
            end
          end
        end
        DECODE:
        begin
          index <= '0;
          phase <= 1'b0;
          state <= DONE;
          if (exec_cmd == CMD_RESTORE || exec_cmd == CMD_BACKUP)
          begin
            if (!is_uhf)
              error <= ERR_NOT_UHF;
            else if (exec_cmd == CMD_RESTORE && !backup_valid)
              error <= ERR_NO_BACKUP;
            else
            begin
              error <= ERR_NONE;
              state <= XFER;
            end
          end
          else if (exec_cmd == CMD_RESET)
          begin
            if (start_addr == RESET_SOFT || start_addr == RESET_VOLT)
            begin
              error              <= ERR_NONE;
              reader_reset       <= 1'b1;
              reader_power_cycle <= (start_addr == RESET_VOLT);
              clear_images       <= 1'b1;
              state              <= CLEAR;
            end
            else
              error <= ERR_BAD_TYPE;
          end
          else
            error <= ERR_BAD_CMD;
        end
        XFER:
        begin
          // Two cycles per word: address, then registered data
          phase <= !phase;
          if (phase)
          begin
            index <= index + AW'(1);
            if (index == AW'(WORDS - 1))
            begin
              state <= DONE;
            end
          end
        end
        CLEAR:
        begin
          // Idle matches the cleared command image, so the reset is not run again
          exec_cmd <= CMD_IDLE;
          rst_ev   <= 1'b1;
          state    <= DONE;
        end
        DONE:
        begin
          response <= (exec_cmd == CMD_IDLE) ? CMD_RESET : exec_cmd;
          done_ev  <= 1'b1;
          err_ev   <= (error != ERR_NONE);
          state    <= IDLE;
        end
        default:
        begin
          state <= IDLE;
        end
      endcase
    end
  end

  // Valid flag is part of the non-volatile store, only power-on clears it
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      backup_valid <= 1'b0;
    end
    else if (state == XFER && phase && exec_cmd == CMD_BACKUP
             && index == AW'(WORDS - 1))
    begin
      backup_valid <= 1'b1;
    end
  end

  // ****************************************
  // Reader and backup transfers
  // ****************************************
  assign busy        = (state != IDLE);
  assign reader_head = channel[CHAN_HEAD_LSB +: 3];
  assign reader_addr = 3'(index);
  assign store_we    = (state == XFER) && phase && (exec_cmd == CMD_BACKUP);
  // Strobe in the data phase, while reader_addr still points at the word being restored
  assign reader_we    = (state == XFER) && phase && (exec_cmd == CMD_RESTORE);
  assign reader_wdata = store_rdata;

  backup_store #(
    .WIDTH (32),
    .DEPTH (WORDS),
    .AW    (AW)
  ) u_store (
    .clock      (clock),
    .write_en   (store_we),
    .write_addr (index),
    .write_data (reader_rdata),
    .read_addr  (index),
    .read_data  (store_rdata)
  );

  // ****************************************
  // Checks
  // ****************************************
  no_restore_hf_a: assert property (@(posedge clock) disable iff (reset)
    reader_we |-> is_uhf) else $error("reader written on non-UHF channel");
  restore_needs_valid_a: assert property (@(posedge clock) disable iff (reset)
    reader_we |-> backup_valid) else $error("restore without valid backup");
  restore_code_a: assert property (@(posedge clock) disable iff (reset)
    reader_we |-> exec_cmd == CMD_RESTORE) else $error("reader write outside restore");
  backup_code_a: assert property (@(posedge clock) disable iff (reset)
    store_we |-> exec_cmd == CMD_BACKUP && is_uhf) else $error("store write outside backup");
  valid_sticky_a: assert property (@(posedge clock) disable iff (reset)
    backup_valid |=> backup_valid) else $error("backup valid lost");
  reset_clears_a: assert property (@(posedge clock) disable iff (reset)
    clear_images |=> command == CMD_IDLE && start_addr == RESET_SOFT)
    else $error("images not cleared");
  reset_type_a: assert property (@(posedge clock) disable iff (reset)
    reader_power_cycle |-> reader_reset) else $error("power cycle without reset");
  reader_reset_a: assert property (@(posedge clock) disable iff (reset)
    reader_reset |-> ##2 done_ev && response == CMD_RESET) else $error("reset not reported");
  response_echo_a: assert property (@(posedge clock) disable iff (reset)
    (state == DONE && exec_cmd != CMD_IDLE) |=> response == $past(exec_cmd))
    else $error("response differs from command");
endmodule

// >>> sim/reader_model.sv
// Behavioural UHF reader holding eight settings words
`timescale 1ns/1ns
module reader_model (
  input  wire logic        clock,
  input  wire logic        reader_we,
  input  wire logic [2:0]  reader_addr,
  input  wire logic [31:0] reader_wdata,
  output logic      [31:0] reader_rdata,
  input  wire logic        reader_reset,
  input  wire logic        reader_power_cycle
);
  logic [31:0] mem [8];
  int          writes       = 0;
  int          resets       = 0;
  int          power_cycles = 0;

  initial
  begin
    for (int i = 0; i < 8; i++)
      mem[i] = 32'hC0DE0000 + i;
    reader_rdata = 32'h0;
  end

  // Synchronous read port: word valid one cycle after the address
  always @(posedge clock)
  begin
    reader_rdata <= mem[reader_addr];
    if (reader_we === 1'h1)
    begin
      mem[reader_addr] <= reader_wdata;
      writes++;
    end
    if (reader_reset === 1'h1)
      resets++;
    // A power cycle loses the settings, so only a restore brings them back
    if (reader_power_cycle === 1'h1)
    begin
      for (int i = 0; i < 8; i++)
        mem[i] <= ~mem[i];
      power_cycles++;
    end
  end
endmodule

// >>> sim/test_maint_cmd.sv
// Register-level testbench for the maintenance command interpreter
`timescale 1ns/1ns
module test_maint_cmd;
  import maint_cmd_pkg::*;
  localparam int WORDS = 8;
  logic clock, reset, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, reader_wdata, reader_rdata, rdata;
  logic [3:0]  wb_sel_i;
  logic        reader_we, reader_reset, reader_power_cycle;
  logic [2:0]  reader_head, reader_addr;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;

  maint_cmd #(.WORDS(WORDS)) dut (.clock(clock), .reset(reset), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq(irq),
    .reader_we(reader_we), .reader_head(reader_head), .reader_addr(reader_addr),
    .reader_wdata(reader_wdata), .reader_rdata(reader_rdata),
    .reader_reset(reader_reset), .reader_power_cycle(reader_power_cycle));

  reader_model rdr (.clock(clock), .reader_we(reader_we), .reader_addr(reader_addr),
    .reader_wdata(reader_wdata), .reader_rdata(reader_rdata),
    .reader_reset(reader_reset), .reader_power_cycle(reader_power_cycle));

  initial
  begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard: the whole sequence needs a few hundred cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Classic single cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'h1);
    rdata = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  // Idle command, then wait until the interpreter is no longer busy
  task automatic idle();
    wb(1'h1, ADDR_COMMAND, 32'h0);
    do wb(1'h0, ADDR_STATUS, 32'h0); while (rdata[0] !== 1'h0);
  endtask

  // Issue a command, wait for done or error, leave the response in rdata
  task automatic run(input logic [15:0] c);
    wb(1'h1, ADDR_IRQ_STAT, 32'h7);
    wb(1'h1, ADDR_COMMAND, {16'h0, c});
    do wb(1'h0, ADDR_IRQ_STAT, 32'h0); while (rdata[1:0] === 2'h0);
    wb(1'h0, ADDR_RESPONSE, 32'h0);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    reset = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    repeat (20) @(posedge clock);
    reset <= 1'h0;
    wb(1'h0, ADDR_STATUS, 32'h0);
    chk("status", rdata, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wb(1'h1, ADDR_CHANNEL, 32'hB);
    chk("head", {29'h0, reader_head}, 32'h5);
    run(CMD_RESTORE);
    chk("resp", rdata, {8'h0, ERR_NO_BACKUP, CMD_RESTORE});
    chk("writes", rdr.writes, 32'h0);
    idle();
    wb(1'h1, ADDR_CHANNEL, 32'hA);
    run(CMD_BACKUP);
    chk("resp", rdata, {8'h0, ERR_NOT_UHF, CMD_BACKUP});
    wb(1'h0, ADDR_STATUS, 32'h0);
    chk("status", rdata, 32'h0);
    idle();
    run(16'h1234);
    chk("resp", rdata, {8'h0, ERR_BAD_CMD, 16'h1234});
    idle();
    wb(1'h1, ADDR_CHANNEL, 32'hB);
    run(CMD_BACKUP);
    chk("resp", rdata, {8'h0, ERR_NONE, CMD_BACKUP});
    wb(1'h0, ADDR_STATUS, 32'h0);
    chk("status", rdata, 32'h2);
    idle();
    wb(1'h1, ADDR_IRQ_MASK, 32'h7);
    wb(1'h1, ADDR_START, {16'h0, RESET_VOLT});
    run(CMD_RESET);
    chk("resp", rdata, {8'h0, ERR_NONE, CMD_RESET});
    chk("resets", rdr.resets, 32'h1);
    chk("pcycles", rdr.power_cycles, 32'h1);
    wb(1'h0, ADDR_COMMAND, 32'h0);
    chk("command", rdata, 32'h0);
    wb(1'h0, ADDR_START, 32'h0);
    chk("start", rdata, 32'h0);
    wb(1'h0, ADDR_IRQ_STAT, 32'h0);
    chk("irqstat", rdata, 32'h5);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'h1, ADDR_IRQ_MASK, 32'h2);
    chk("irq", {31'h0, irq}, 32'h0);
    wb(1'h1, ADDR_IRQ_MASK, 32'h4);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'h1, ADDR_IRQ_STAT, 32'h7);
    chk("irq", {31'h0, irq}, 32'h0);
    wb(1'h0, 8'hF0, 32'h0);
    chk("unmapped", rdata, 32'h0);
    idle();
    wb(1'h1, ADDR_START, {16'h0, RESET_SOFT});
    run(CMD_RESET);
    chk("resp", rdata, {8'h0, ERR_NONE, CMD_RESET});
    chk("resets", rdr.resets, 32'h2);
    chk("pcycles", rdr.power_cycles, 32'h1);
    wb(1'h0, ADDR_STATUS, 32'h0);
    chk("status", rdata, 32'h2);
    idle();
    wb(1'h1, ADDR_CHANNEL, 32'hB);
    run(CMD_RESTORE);
    chk("resp", rdata, {8'h0, ERR_NONE, CMD_RESTORE});
    chk("writes", rdr.writes, WORDS);
    for (int i = 0; i < WORDS; i++)
      chk("word", rdr.mem[i], 32'hC0DE0000 + i);
    idle();
    // Low byte lane only: the upper byte of the start address must stay zero
    wb_sel_i <= 4'h1;
    wb(1'h1, ADDR_START, 32'hFF02);
    wb_sel_i <= 4'hF;
    wb(1'h0, ADDR_START, 32'h0);
    chk("start", rdata, 32'h2);
    run(CMD_RESET);
    chk("resp", rdata, {8'h0, ERR_BAD_TYPE, CMD_RESET});
    chk("resets", rdr.resets, 32'h2);
    tally_and_finish();
  end
endmodule
